// ===== hw/lpms_sequencer.sv
// Notes on behaviour
// - wait gates cpu clock, peripherals keep running
// - wait holds registers, ram and pins
// - wait exits on interrupt, reset, standby
// - interrupt wake vectors, or resumes if masked
// - peripheral-masked sources never release wait
// - no serial retrigger once wait entered
// - stop halts oscillator, cpu and peripherals
// - stop exits on external lines, reset, standby
// - stop wake vectors, or resumes if masked
// - masked second external line keeps stop
// - interrupt stop exit waits oscillator settling
// - reset exit restarts oscillator, cpu on release
// - standby stops all, resets state, floats pins
// - external pin and power-on reset both reset
`timescale 1ns/1ps
`default_nettype none
module lpms_sequencer #(
  parameter int unsigned SETTLE_CYCLES = lpms_pkg::SETTLE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic ext_reset_n,
  input  wire logic standby_pin_n,
  input  wire logic ext_irq_first_n,
  input  wire logic ext_irq_second_n,
  input  wire logic ext_irq_second_mask,
  input  wire logic tmr_irq_req,
  input  wire logic tmr_irq_mask,
  input  wire logic ser_irq_req,
  input  wire logic ser_irq_mask,
  input  wire logic cpu_irq_mask,
  input  wire logic wait_instr,
  input  wire logic stop_instr,
  output var  logic osc_run,
  output var  logic cpu_clk_en,
  output var  logic periph_clk_en,
  output var  logic core_reset,
  output var  logic pins_hiz,
  output var  logic hold_state,
  output var  logic wake_vector,
  output var  logic wake_resume,
  output var  logic serial_retrig_block,
  output var  logic [2:0] mode_state
);
  import lpms_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       rst_pin_n;
  logic       standby_pin_n_n;
  logic       irq1_n;
  logic       irq2_n;

  lpms_pin_sync #(
    .W       (4),
    .RST_VAL (4'h0)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  ({ext_reset_n, standby_pin_n, ext_irq_first_n, ext_irq_second_n}),
    .pin_out (pins_s)
  );

  assign rst_pin_n = pins_s[3];
  assign standby_pin_n_n    = pins_s[2];
  assign irq1_n    = pins_s[1];
  assign irq2_n    = pins_s[0];

  // --------------------------------------------------------------------------
  // request qualification
  // --------------------------------------------------------------------------
  // a source masked at its own peripheral never reaches the core
  function automatic logic gated(input logic req, input logic mask);
    gated = req & ~mask;
  endfunction

  logic [IRQ_SRC_N-1:0] irq_req;
  logic                 wake_wait;
  logic                 wake_stop;

  always_comb
  begin
    irq_req[SRC_EXT1]     = ~irq1_n;
    irq_req[SRC_TMR_EXT2] = gated(tmr_irq_req, tmr_irq_mask)
                            | gated(~irq2_n, ext_irq_second_mask);
    irq_req[SRC_SER_TMR2] = gated(ser_irq_req, ser_irq_mask);
  end

  assign wake_wait = |irq_req;
  assign wake_stop = ~irq1_n | gated(~irq2_n, ext_irq_second_mask);

  // --------------------------------------------------------------------------
  // internal power-on reset stretch
  // --------------------------------------------------------------------------
  logic [POR_W-1:0] por_cnt_r;
  logic             por_done;

  // counts after release of the async reset; holds the core in reset till done
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      por_cnt_r <= '0;
    else if (!por_done)
      por_cnt_r <= por_cnt_r + POR_W'(1);

  assign por_done = (por_cnt_r == POR_W'(POR_CYC));

  // --------------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------------
  lpms_state_e       state_r;
  lpms_state_e       state_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic              settle_done;

  assign settle_done = (settle_r == SETTLE_W'(SETTLE_CYCLES - 1));

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LPMS_ST_POR:
        if (por_done)
          state_nxt = LPMS_ST_RESET;
      LPMS_ST_ACTIVE:
        if (stop_instr)
          state_nxt = LPMS_ST_STOP;
        else if (wait_instr)
          state_nxt = LPMS_ST_WAIT;
      LPMS_ST_WAIT:
        if (wake_wait)
          state_nxt = LPMS_ST_ACTIVE;
      LPMS_ST_STOP:
        if (wake_stop)
          state_nxt = LPMS_ST_SETTLE;
      LPMS_ST_SETTLE:
        if (settle_done)
          state_nxt = LPMS_ST_ACTIVE;
      LPMS_ST_RESET:
        if (rst_pin_n)
          state_nxt = LPMS_ST_ACTIVE;
      LPMS_ST_STANDBY:
        if (standby_pin_n_n)
          state_nxt = LPMS_ST_RESET;
      default:
        state_nxt = LPMS_ST_RESET;
    endcase
    // reset pin takes precedence over any mode but power-on reset and standby
    if (state_r != LPMS_ST_POR && state_r != LPMS_ST_STANDBY && !rst_pin_n)
      state_nxt = LPMS_ST_RESET;
    // standby pin beats every mode but power-on reset, pending wakes included
    if (state_r != LPMS_ST_POR && !standby_pin_n_n)
      state_nxt = LPMS_ST_STANDBY;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      state_r <= LPMS_ST_POR;
    else
      state_r <= state_nxt;

  // settling counter runs only while the oscillator restarts
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      settle_r <= '0;
    else if (state_r == LPMS_ST_SETTLE && !settle_done)
      settle_r <= settle_r + SETTLE_W'(1);
    else if (state_r != LPMS_ST_SETTLE)
      settle_r <= '0;

  // --------------------------------------------------------------------------
  // wake outcome: vector if accepted, resume after sleep instruction if masked
  // --------------------------------------------------------------------------
  logic wake_evt;

  assign wake_evt = (state_r == LPMS_ST_WAIT && state_nxt == LPMS_ST_ACTIVE)
                    || (state_r == LPMS_ST_SETTLE && state_nxt == LPMS_ST_ACTIVE);

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      wake_vector <= 1'b0;
      wake_resume <= 1'b0;
    end
    else
    begin
      wake_vector <= wake_evt & ~cpu_irq_mask;
      wake_resume <= wake_evt & cpu_irq_mask;
    end

  // --------------------------------------------------------------------------
  // serial retrigger lock, set on wait entry, freed on leaving wait
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      serial_retrig_block <= 1'b0;
    else
      serial_retrig_block <= (state_nxt == LPMS_ST_WAIT);

  // --------------------------------------------------------------------------
  // registered control outputs, decoded from next state
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      osc_run       <= 1'b0;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      core_reset    <= 1'b1;
      pins_hiz      <= 1'b0;
      hold_state    <= 1'b0;
      mode_state    <= 3'h0;
    end
    else
    begin
      // oscillator runs in reset so it settles before the cpu starts
      osc_run       <= state_nxt inside {LPMS_ST_ACTIVE, LPMS_ST_WAIT,
                                         LPMS_ST_SETTLE, LPMS_ST_RESET};
      cpu_clk_en    <= (state_nxt == LPMS_ST_ACTIVE);
      periph_clk_en <= state_nxt inside {LPMS_ST_ACTIVE, LPMS_ST_WAIT};
      core_reset    <= state_nxt inside {LPMS_ST_POR, LPMS_ST_RESET,
                                         LPMS_ST_STANDBY};
      pins_hiz      <= (state_nxt == LPMS_ST_STANDBY);
      hold_state    <= state_nxt inside {LPMS_ST_WAIT, LPMS_ST_STOP,
                                         LPMS_ST_SETTLE};
      mode_state    <= 3'(state_nxt);
    end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_stop_wake;
    state_r == LPMS_ST_STOP && wake_stop && standby_pin_n_n && rst_pin_n;
  endsequence

  // standby or reset may legally cut settling short, so only the cpu clock is held on the second cycle
  sequence s_settling;
    state_r == LPMS_ST_SETTLE && !cpu_clk_en ##1 !cpu_clk_en;
  endsequence

  a_standby_override: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_r != LPMS_ST_POR && !standby_pin_n_n) |=> state_r == LPMS_ST_STANDBY)
    else $error("standby pin did not force standby");

  a_standby_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == LPMS_ST_STANDBY |-> pins_hiz && core_reset && !osc_run)
    else $error("standby outputs wrong");

  a_wait_clocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == LPMS_ST_WAIT |-> !cpu_clk_en && periph_clk_en && osc_run)
    else $error("wait clock gating wrong");

  a_wait_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_r == LPMS_ST_WAIT && irq1_n && !gated(ser_irq_req, ser_irq_mask)
     && !gated(tmr_irq_req, tmr_irq_mask) && (irq2_n || ext_irq_second_mask)
     && standby_pin_n_n && rst_pin_n) |=> state_r == LPMS_ST_WAIT)
    else $error("masked source released wait");

  a_stop_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_r == LPMS_ST_STOP && irq1_n && ext_irq_second_mask && standby_pin_n_n && rst_pin_n)
    |=> state_r == LPMS_ST_STOP)
    else $error("masked line released stop");

  a_stop_settle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_stop_wake |=> s_settling)
    else $error("cpu woke before settling");

  a_wake_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wake_evt && !cpu_irq_mask) |=> wake_vector && !wake_resume)
    else $error("wake vector missing");

  a_retrig_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_r == LPMS_ST_WAIT |-> serial_retrig_block)
    else $error("serial retrigger not blocked in wait");

  a_reset_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_r == LPMS_ST_RESET && !rst_pin_n && standby_pin_n_n) |=> core_reset && osc_run)
    else $error("reset exit sequencing wrong");
endmodule
`default_nettype wire

// ===== hw/lpms_pkg.sv
// ----------------------------------------------------------------------------
// shared constants for the low power mode sequencer
// ----------------------------------------------------------------------------
package lpms_pkg;
  // core clock rate
  localparam int unsigned CLK_HZ        = 100_000_000;
  // oscillator settling delay after an interrupt wake, in microseconds
  localparam int unsigned SETTLE_US     = 1000;
  localparam int unsigned SETTLE_CYC    = (CLK_HZ / 1_000_000) * SETTLE_US;
  localparam int unsigned SETTLE_W      = 24;
  // power-up reset hold the outside world must give, in milliseconds
  localparam int unsigned PWRUP_HOLD_MS = 20;
  // internal power-on reset stretch, in cycles
  localparam int unsigned POR_CYC       = 16;
  localparam int unsigned POR_W         = 5;
  // number of interrupt sources seen by the sequencer
  localparam int unsigned IRQ_SRC_N     = 3;
  localparam int unsigned SRC_EXT1      = 0;
  localparam int unsigned SRC_TMR_EXT2  = 1;
  localparam int unsigned SRC_SER_TMR2  = 2;

  typedef enum logic [2:0] {
    LPMS_ST_POR,
    LPMS_ST_ACTIVE,
    LPMS_ST_WAIT,
    LPMS_ST_STOP,
    LPMS_ST_SETTLE,
    LPMS_ST_RESET,
    LPMS_ST_STANDBY
  } lpms_state_e;
endpackage

// ===== hw/lpms_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// three-stage pin synchroniser; output moves once stages two and three agree
// ----------------------------------------------------------------------------
module lpms_pin_sync #(
  parameter int unsigned  W        = 1,
  parameter logic [W-1:0] RST_VAL  = '1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // shift chain; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end

  // per bit agreement filter
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      pin_out <= RST_VAL;
    else
      for (int i = 0; i < W; i++)
        if (s2_r[i] == s3_r[i])
          pin_out[i] <= s3_r[i];
endmodule
`default_nettype wire

// ===== verif/lpms_ext_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// board-side reset and standby controller
// ----------------------------------------------------------------------------
module lpms_ext_ctrl #(
  parameter int unsigned HOLD_CYC = 8
) (
  input  wire logic clk_sys,
  input  wire logic rst_req,
  input  wire logic sby_req,
  output wire logic ext_reset_n,
  output wire logic standby_pin_n
);
  int unsigned hold_r  = HOLD_CYC;
  logic        rst_n_r = 1'b0;
  logic        sby_n_r = 1'b1;

  // hold count reloads on every request; kept above settling so the core never wakes early
  always @(posedge clk_sys)
    if (rst_req || sby_req)
      hold_r <= HOLD_CYC;
    else if (hold_r != 0)
      hold_r <= hold_r - 1;

  // pins move only on the clock, as a real supervisor would after its own filter
  always @(posedge clk_sys)
  begin
    rst_n_r <= (hold_r == 0) && !rst_req && !sby_req;
    sby_n_r <= !sby_req;
  end

  assign ext_reset_n   = rst_n_r;
  assign standby_pin_n = sby_n_r;
endmodule
`default_nettype wire

// ===== verif/low_power_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_sequencer_tb;
  import lpms_pkg::*;
  localparam int unsigned SIM_SETTLE = 4;
  logic clk_sys, reset_n, ext_reset_n, standby_pin_n, ext_irq_first_n, ext_irq_second_n;
  logic ext_irq_second_mask, tmr_irq_req, tmr_irq_mask, ser_irq_req, ser_irq_mask;
  logic cpu_irq_mask, wait_instr, stop_instr, osc_run, cpu_clk_en, periph_clk_en;
  logic core_reset, pins_hiz, hold_state, wake_vector, wake_resume, serial_retrig_block;
  logic [2:0] mode_state;
  logic rst_req, sby_req;
  int   error_cnt, tests_run, nv, nr, nv0, nr0;

  // ----------------------------------------------------------------------------
  // block, board controller and clock
  // ----------------------------------------------------------------------------
  lpms_sequencer #(.SETTLE_CYCLES(SIM_SETTLE)) u_dut (
    .clk_sys, .reset_n, .ext_reset_n, .standby_pin_n, .ext_irq_first_n, .ext_irq_second_n,
    .ext_irq_second_mask, .tmr_irq_req, .tmr_irq_mask, .ser_irq_req, .ser_irq_mask,
    .cpu_irq_mask, .wait_instr, .stop_instr, .osc_run, .cpu_clk_en, .periph_clk_en,
    .core_reset, .pins_hiz, .hold_state, .wake_vector, .wake_resume, .serial_retrig_block,
    .mode_state);

  lpms_ext_ctrl u_ctrl (.clk_sys, .rst_req, .sby_req, .ext_reset_n, .standby_pin_n);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // wake pulses tallied per edge, so a stuck pulse shows up as a count above one
  always @(posedge clk_sys)
  begin
    nv <= nv + int'(wake_vector === 1'b1);
    nr <= nr + int'(wake_resume === 1'b1);
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic until_st(input logic [2:0] code, input int max);
    int n;
    n = 0;
    while (mode_state !== code && n < max)
    begin
      cyc(1);
      n++;
    end
    chk(mode_state === code, "state not reached");
  endtask

  task automatic enter(input logic st);
    stop_instr = st;
    wait_instr = !st;
    cyc(1);
    stop_instr = 1'b0;
    wait_instr = 1'b0;
    until_st(st ? LPMS_ST_STOP : LPMS_ST_WAIT, 4);
    cyc(1);
  endtask

  task automatic set_src(input int i, input logic on);
    case (i)
      0: ext_irq_first_n = !on;
      1: tmr_irq_req = on;
      2: ext_irq_second_n = !on;
      default: ser_irq_req = on;
    endcase
  endtask

  // requests drop before masks so a late synced line cannot wake on the way out
  task automatic masked_reqs(input logic on);
    tmr_irq_mask        = 1'b1;
    ser_irq_mask        = 1'b1;
    ext_irq_second_mask = 1'b1;
    tmr_irq_req         = on;
    ser_irq_req         = on;
    ext_irq_second_n    = !on;
    cyc(8);
    tmr_irq_mask        = on;
    ser_irq_mask        = on;
    ext_irq_second_mask = on;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_wait(input int src, input logic im);
    cpu_irq_mask = im;
    enter(1'b0);
    chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b1 && osc_run === 1'b1, "wait clocks");
    chk(hold_state === 1'b1 && serial_retrig_block === 1'b1 && pins_hiz === 1'b0, "wait hold");
    masked_reqs(1'b1);
    chk(mode_state === LPMS_ST_WAIT, "masked wake");
    masked_reqs(1'b0);
    nv0 = nv;
    nr0 = nr;
    set_src(src, 1'b1);
    until_st(LPMS_ST_ACTIVE, 12);
    cyc(2);
    chk(nv - nv0 == int'(!im) && nr - nr0 == int'(im), "wait wake kind");
    chk(serial_retrig_block === 1'b0 && hold_state === 1'b0 && cpu_clk_en === 1'b1, "wait exit");
    set_src(src, 1'b0);
    cyc(8);
  endtask

  task automatic t_stop(input int src, input logic im);
    int   n;
    logic bad;
    cpu_irq_mask = im;
    enter(1'b1);
    chk(osc_run === 1'b0 && periph_clk_en === 1'b0 && cpu_clk_en === 1'b0 && hold_state === 1'b1, "stop clocks");
    masked_reqs(1'b1);
    tmr_irq_mask = 1'b0;
    ser_irq_mask = 1'b0;
    cyc(8);
    chk(mode_state === LPMS_ST_STOP, "stop left early");
    masked_reqs(1'b0);
    nv0 = nv;
    nr0 = nr;
    n   = 0;
    bad = 1'b0;
    set_src(src, 1'b1);
    until_st(LPMS_ST_SETTLE, 10);
    while (mode_state === LPMS_ST_SETTLE && n < 20)
    begin
      bad = bad || cpu_clk_en !== 1'b0 || (n > 0 && osc_run !== 1'b1);
      cyc(1);
      n++;
    end
    chk(!bad && n == SIM_SETTLE, "settle");
    cyc(2);
    chk(mode_state === LPMS_ST_ACTIVE && nv - nv0 == int'(!im) && nr - nr0 == int'(im), "stop wake");
    set_src(src, 1'b0);
    cyc(8);
  endtask

  task automatic t_pin_reset(input logic st);
    enter(st);
    rst_req = 1'b1;
    cyc(1);
    rst_req = 1'b0;
    until_st(LPMS_ST_RESET, 10);
    cyc(1);
    chk(osc_run === 1'b1 && core_reset === 1'b1 && cpu_clk_en === 1'b0, "reset hold");
    until_st(LPMS_ST_ACTIVE, 30);
    cyc(1);
    chk(core_reset === 1'b0 && cpu_clk_en === 1'b1, "reset exit");
  endtask

  task automatic t_standby;
    enter(1'b0);
    nv0             = nv;
    nr0             = nr;
    // the board pin lags the request by one edge, so the wake line follows one cycle later to land together
    sby_req         = 1'b1;
    cyc(1);
    ext_irq_first_n = 1'b0;
    until_st(LPMS_ST_STANDBY, 10);
    stop_instr = 1'b1;
    cyc(1);
    stop_instr = 1'b0;
    cyc(8);
    chk(mode_state === LPMS_ST_STANDBY && pins_hiz === 1'b1, "standby");
    chk(nv == nv0 && nr == nr0, "wake beat standby");
    chk(osc_run === 1'b0 && core_reset === 1'b1 && cpu_clk_en === 1'b0, "standby stop");
    ext_irq_first_n = 1'b1;
    sby_req         = 1'b0;
    until_st(LPMS_ST_ACTIVE, 40);
    cyc(1);
    chk(pins_hiz === 1'b0 && core_reset === 1'b0, "standby exit");
  endtask

  task automatic t_por;
    reset_n = 1'b0;
    cyc(2);
    chk(core_reset === 1'b1 && mode_state === LPMS_ST_POR, "por");
    reset_n = 1'b1;
    until_st(LPMS_ST_ACTIVE, 60);
  endtask

  // watchdog: the whole run needs under 500 cycles, so 20000 means a hang
  initial
  begin
    #200_000;
    error_cnt++;
    report_and_stop;
  end

  initial
  begin
    {reset_n, rst_req, sby_req, tmr_irq_req, ser_irq_req, wait_instr, stop_instr} = '0;
    {tmr_irq_mask, ser_irq_mask, ext_irq_second_mask, cpu_irq_mask} = '0;
    {ext_irq_first_n, ext_irq_second_n} = 2'b11;
    error_cnt = 0;
    tests_run = 0;
    cyc(12);
    reset_n = 1'b1;
    until_st(LPMS_ST_ACTIVE, 60);
    for (int s = 0; s < 4; s++)
      t_wait(s, logic'(s % 2));
    t_stop(0, 1'b0);
    t_stop(2, 1'b1);
    t_pin_reset(1'b1);
    t_pin_reset(1'b0);
    t_standby;
    t_por;
    report_and_stop;
  end
endmodule
`default_nettype wire
